/* rtl/csc_regs.svh */
// offsets, bit fields, reset values and timing of the two-wire link
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH
`define CSC_SLAVE_ADDR 7'h69
`define CSC_CMD_BYTE_OP 3'h4
`define CSC_OFF_DRIVE_FREQ 7'h00
`define CSC_OFF_DIFF_OE 7'h01
`define CSC_RST_BYTE0 8'h4C
`define CSC_RST_BYTE1 8'h7F
`define CSC_B0_PCI_DRIVE 6
`define CSC_B1_SRC_STOP 7
`define CSC_B1_SRC_OE 6
`define CSC_B1_ITP_OE 2
`define CSC_B1_CPU1_OE 1
`define CSC_B1_CPU0_OE 0
`define CSC_STRAP_SETTLE 2'h3
`define CSC_H_ADDR_OFFSET 8'h00
`define CSC_H_ADDR_WDATA 8'h01
`define CSC_H_ADDR_CTRL 8'h02
`define CSC_H_ADDR_STATUS 8'h03
`define CSC_H_ADDR_RDATA 8'h04
`define CSC_H_CTRL_GO 0
`define CSC_H_CTRL_READ 1
`define CSC_H_ST_BUSY 0
`define CSC_H_ST_NACK 1
`define CSC_H_ST_DONE 2
`define CSC_H_STEP_STOP_WR 3'h4
`define CSC_H_STEP_STOP_RD 3'h6
`define CSC_CLK_PERIOD_NS 20
`define CSC_SCL_PERIOD_NS 10000
`define CSC_SCL_QUARTER (`CSC_SCL_PERIOD_NS / (4 * `CSC_CLK_PERIOD_NS))
`endif

/* rtl/csc_pkg.sv */
// state and step types shared by both ends of the link
package csc_pkg;
    typedef enum logic [2:0] {
        CSC_D_IDLE = 3'b000,
        CSC_D_RX = 3'b001,
        CSC_D_ACK = 3'b010,
        CSC_D_TX = 3'b011,
        CSC_D_MACK = 3'b100,
        CSC_D_IGNORE = 3'b101
    } csc_dev_state_type;
    typedef enum logic [1:0] {
        CSC_PH_ADDR = 2'b00,
        CSC_PH_CMD = 2'b01,
        CSC_PH_DATA = 2'b10
    } csc_phase_type;
    typedef enum logic {
        CSC_H_IDLE = 1'b0,
        CSC_H_RUN = 1'b1
    } csc_host_state_type;
    typedef enum logic [2:0] {
        CSC_K_START = 3'b000,
        CSC_K_TX = 3'b001,
        CSC_K_RX = 3'b010,
        CSC_K_STOP = 3'b011,
        CSC_K_DONE = 3'b100
    } csc_step_type;
endpackage

/* rtl/csc_smbus_if.sv */
// open-drain two-wire link joining host and device ends
interface csc_smbus_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // pull-ups: a line is low only while someone drives a zero
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
    modport host_end (
        output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
        input scl, sda
    );
    modport device_end (
        output dev_sda_o, dev_sda_oe,
        input scl, sda
    );
endinterface

/* rtl/csc_sync.sv */
// two-flop synchroniser for inputs from outside the clock domain
module csc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

/* rtl/csc_device.sv */
// device end: serial slave and the first two configuration bytes
// How it works
// - start, address, write bit, two acknowledges
// - command 100xxxxx selects byte, offset low seven
// - byte write: data, store, acknowledge, stop
// - byte read: repeated start, read address, acknowledge
// - device sends byte msb first, host acks, stop
// - byte0 bit6 PCI drive strength, resets high
// - byte0 bits1:0 report latched frequency selects
// - software writes reserved bits with fixed values
// - byte1 bit7 lets reference pair stop
// - byte1 differential output enables reset high
// - answer only slave address byte D2, and D3 after a command
// - stop and resume clocks together, no runts
//
// Implementation choice: the address-and-strobe port.
`include "csc_regs.svh"
module csc_device (
    input wire logic clk,
    input wire logic rst,
    csc_smbus_if.device_end bus,
    input wire logic freq_select_first,
    input wire logic freq_select_second,
    input wire logic software_pci_clock_stop,
    output logic pci_drive_high,
    output logic serial_ref_clock_oe,
    output logic debug_port_cpu_clock_oe,
    output logic cpu_clock1_oe,
    output logic cpu_clock0_oe,
    output logic serial_ref_clock_run,
    output logic pci_clock_run,
    output logic [1:0] freq_select_latched
);
    import csc_pkg::*;

    typedef struct packed {
        csc_dev_state_type state;
        csc_phase_type phase;
        csc_dev_state_type nxt;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic scl_p;
        logic sda_p;
        logic ack_go;
        logic rd_ok;
        logic [6:0] off;
        logic [7:0] txb;
        logic drv;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [1:0] fs;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic run_pci;
        logic run_src;
    } csc_dev_regs_type;

    localparam csc_dev_regs_type DEV_RST = '{
        state: CSC_D_IDLE,
        phase: CSC_PH_ADDR,
        nxt: CSC_D_IDLE,
        scl_p: 1'b1,
        sda_p: 1'b1,
        b0: `CSC_RST_BYTE0,
        b1: `CSC_RST_BYTE1,
        run_pci: 1'b1,
        run_src: 1'b1,
        default: '0
    };

    csc_dev_regs_type q;
    csc_dev_regs_type d;
    logic [3:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rx_byte;

    csc_sync #(
        .W(4),
        .RST_VAL(4'hF)
    ) i_csc_sync (
        .clk(clk),
        .rst(rst),
        .d({freq_select_second, freq_select_first, bus.sda, bus.scl}),
        .q(sync_q)
    );

    // configuration byte as seen by a read
    function automatic logic [7:0] dev_read(
        input logic [6:0] off,
        input logic [7:0] b0,
        input logic [1:0] fs,
        input logic [7:0] b1
    );
        logic [7:0] r;
        r = 8'h00;
        if (off == `CSC_OFF_DRIVE_FREQ) begin
            r = {b0[7:2], fs};
        end else if (off == `CSC_OFF_DIFF_OE) begin
            r = b1;
        end
        return r;
    endfunction

    assign scl_s = sync_q[0];
    assign sda_s = sync_q[1];
    assign scl_rise = scl_s & ~q.scl_p;
    assign scl_fall = ~scl_s & q.scl_p;
    assign start_seen = scl_s & q.scl_p & q.sda_p & ~sda_s;
    assign stop_seen = scl_s & q.scl_p & ~q.sda_p & sda_s;
    assign rx_byte = {q.sh[6:0], sda_s};

    always_comb begin
        d = q;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        // pins settle through the synchroniser before the latch
        if (!q.strap_done) begin
            d.strap_cnt = q.strap_cnt + 2'h1;
            if (q.strap_cnt == `CSC_STRAP_SETTLE) begin
                d.fs = sync_q[3:2];
                d.strap_done = 1'b1;
            end
        end
        // both run flags move in the same edge when byte1 bit7 is set
        d.run_pci = ~software_pci_clock_stop;
        d.run_src = ~(software_pci_clock_stop
            & q.b1[`CSC_B1_SRC_STOP]);
        if (stop_seen) begin
            d.state = CSC_D_IDLE;
            d.drv = 1'b0;
            d.rd_ok = 1'b0;
        end else if (start_seen) begin
            d.state = CSC_D_RX;
            d.phase = CSC_PH_ADDR;
            d.cnt = 3'h0;
            d.drv = 1'b0;
        end else begin
            unique case (q.state)
                CSC_D_IDLE, CSC_D_IGNORE: begin
                    d.drv = 1'b0;
                end
                CSC_D_RX: begin
                    if (scl_rise) begin
                        d.sh = rx_byte;
                        d.cnt = q.cnt + 3'h1;
                        if (q.cnt == 3'h7) begin
                            d.state = CSC_D_ACK;
                            d.ack_go = 1'b0;
                            d.nxt = CSC_D_IGNORE;
                            unique case (q.phase)
                                CSC_PH_ADDR: begin
                                    if (rx_byte[7:1] == `CSC_SLAVE_ADDR) begin
                                        if (!rx_byte[0]) begin
                                            d.ack_go = 1'b1;
                                            d.nxt = CSC_D_RX;
                                            d.phase = CSC_PH_CMD;
                                        end else if (q.rd_ok) begin
                                            d.ack_go = 1'b1;
                                            d.nxt = CSC_D_TX;
                                            d.txb = dev_read(q.off, q.b0,
                                                q.fs, q.b1);
                                        end
                                    end
                                end
                                CSC_PH_CMD: begin
                                    if (rx_byte[7:5] == `CSC_CMD_BYTE_OP) begin
                                        d.ack_go = 1'b1;
                                        d.off = rx_byte[6:0];
                                        d.rd_ok = 1'b1;
                                        d.nxt = CSC_D_RX;
                                        d.phase = CSC_PH_DATA;
                                    end
                                end
                                CSC_PH_DATA: begin
                                    d.ack_go = 1'b1;
                                    d.rd_ok = 1'b0;
                                    if (q.off == `CSC_OFF_DRIVE_FREQ) begin
                                        d.b0 = rx_byte;
                                    end else if (q.off == `CSC_OFF_DIFF_OE) begin
                                        d.b1 = rx_byte;
                                    end
                                end
                                default: begin
                                    d.ack_go = 1'b0;
                                end
                            endcase
                        end
                    end
                end
                CSC_D_ACK: begin
                    if (scl_fall) begin
                        if (!q.drv) begin
                            d.drv = q.ack_go;
                            if (!q.ack_go) begin
                                d.state = CSC_D_IGNORE;
                            end
                        end else begin
                            d.state = q.nxt;
                            d.cnt = 3'h0;
                            d.drv = (q.nxt == CSC_D_TX) ? ~q.txb[7] : 1'b0;
                        end
                    end
                end
                CSC_D_TX: begin
                    if (scl_rise) begin
                        d.cnt = q.cnt + 3'h1;
                    end
                    if (scl_fall) begin
                        if (q.cnt == 3'h0) begin
                            d.drv = 1'b0;
                            d.state = CSC_D_MACK;
                        end else begin
                            d.drv = ~q.txb[3'h7 - q.cnt];
                        end
                    end
                end
                CSC_D_MACK: begin
                    if (scl_rise) begin
                        d.state = CSC_D_IGNORE;
                    end
                end
                default: begin
                    d.state = CSC_D_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = q.drv;
    assign pci_drive_high = q.b0[`CSC_B0_PCI_DRIVE];
    assign serial_ref_clock_oe = q.b1[`CSC_B1_SRC_OE];
    assign debug_port_cpu_clock_oe = q.b1[`CSC_B1_ITP_OE];
    assign cpu_clock1_oe = q.b1[`CSC_B1_CPU1_OE];
    assign cpu_clock0_oe = q.b1[`CSC_B1_CPU0_OE];
    assign serial_ref_clock_run = q.run_src;
    assign pci_clock_run = q.run_pci;
    assign freq_select_latched = q.fs;
endmodule

/* rtl/csc_host.sv */
// host end: byte read and write master with its own command registers
`include "csc_regs.svh"
module csc_host #(
    parameter int QUARTER = `CSC_SCL_QUARTER
) (
    input wire logic clk,
    input wire logic rst,
    csc_smbus_if.host_end bus,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata
);
    import csc_pkg::*;

    typedef struct packed {
        csc_pkg::csc_host_state_type state;
        logic [15:0] div;
        logic [1:0] qtr;
        logic [3:0] bitn;
        logic [2:0] step;
        logic [7:0] rx;
        logic scl_oe;
        logic sda_oe;
        logic nack;
        logic done;
        logic rd_op;
        logic [6:0] off;
        logic [7:0] wdat;
        logic [7:0] rdata;
    } csc_host_regs_type;

    csc_host_regs_type q;
    csc_host_regs_type d;
    logic sda_s;
    logic tick;
    csc_step_type kind;
    logic [7:0] txb;
    logic [2:0] stop_step;

    csc_sync #(
        .W(1),
        .RST_VAL(1'h1)
    ) i_csc_sync (
        .clk(clk),
        .rst(rst),
        .d(bus.sda),
        .q(sda_s)
    );

    // symbol sent in each step of a byte write or byte read
    function automatic csc_step_type host_kind(
        input logic rd_op,
        input logic [2:0] step
    );
        csc_step_type k;
        k = CSC_K_DONE;
        case (step)
            3'h0: k = CSC_K_START;
            3'h1, 3'h2: k = CSC_K_TX;
            3'h3: k = rd_op ? CSC_K_START : CSC_K_TX;
            3'h4: k = rd_op ? CSC_K_TX : CSC_K_STOP;
            3'h5: k = rd_op ? CSC_K_RX : CSC_K_DONE;
            3'h6: k = rd_op ? CSC_K_STOP : CSC_K_DONE;
            default: k = CSC_K_DONE;
        endcase
        return k;
    endfunction

    function automatic logic [7:0] host_tx(
        input logic [2:0] step,
        input logic [6:0] off,
        input logic [7:0] wdat
    );
        logic [7:0] t;
        t = 8'h00;
        case (step)
            3'h1: t = {`CSC_SLAVE_ADDR, 1'b0};
            3'h2: t = {1'b1, off};
            3'h3: t = wdat;
            3'h4: t = {`CSC_SLAVE_ADDR, 1'b1};
            default: t = 8'h00;
        endcase
        return t;
    endfunction

    assign kind = host_kind(q.rd_op, q.step);
    assign txb = host_tx(q.step, q.off, q.wdat);
    assign tick = q.div == 16'(QUARTER - 1);
    assign stop_step = q.rd_op ? `CSC_H_STEP_STOP_RD : `CSC_H_STEP_STOP_WR;

    always_comb begin
        d = q;
        d.rdata = 8'h00;
        unique case (q.state)
            CSC_H_IDLE: begin
                d.div = 16'h0000;
            end
            CSC_H_RUN: begin
                d.div = tick ? 16'h0000 : q.div + 16'h0001;
                if (tick) begin
                    d.qtr = q.qtr + 2'h1;
                    unique case (kind)
                        CSC_K_START: begin
                            unique case (q.qtr)
                                2'h0: d.sda_oe = 1'b0;
                                2'h1: d.scl_oe = 1'b0;
                                2'h2: d.sda_oe = 1'b1;
                                2'h3: begin
                                    d.scl_oe = 1'b1;
                                    d.step = q.step + 3'h1;
                                end
                            endcase
                        end
                        CSC_K_STOP: begin
                            unique case (q.qtr)
                                2'h0: d.sda_oe = 1'b1;
                                2'h1: d.scl_oe = 1'b0;
                                2'h2: d.sda_oe = 1'b0;
                                2'h3: d.step = q.step + 3'h1;
                            endcase
                        end
                        CSC_K_TX, CSC_K_RX: begin
                            unique case (q.qtr)
                                2'h0: begin
                                    if (kind == CSC_K_TX) begin
                                        d.sda_oe = (q.bitn != 4'h8)
                                            & ~txb[3'h7 - q.bitn[2:0]];
                                    end else begin
                                        d.sda_oe = q.bitn == 4'h8;
                                    end
                                end
                                2'h1: d.scl_oe = 1'b0;
                                2'h2: begin
                                    if (q.bitn != 4'h8) begin
                                        d.rx = {q.rx[6:0], sda_s};
                                    end else if (kind == CSC_K_TX && sda_s) begin
                                        d.nack = 1'b1;
                                    end
                                end
                                2'h3: begin
                                    d.scl_oe = 1'b1;
                                    d.bitn = q.bitn + 4'h1;
                                    if (q.bitn == 4'h8) begin
                                        d.bitn = 4'h0;
                                        d.step = q.nack ? stop_step
                                            : q.step + 3'h1;
                                    end
                                end
                            endcase
                        end
                        CSC_K_DONE: begin
                            d.state = CSC_H_IDLE;
                            d.done = 1'b1;
                        end
                        default: begin
                            d.state = CSC_H_IDLE;
                        end
                    endcase
                end
            end
        endcase
        if (rd) begin
            case (addr)
                `CSC_H_ADDR_OFFSET: d.rdata = {1'b0, q.off};
                `CSC_H_ADDR_WDATA: d.rdata = q.wdat;
                `CSC_H_ADDR_STATUS: d.rdata = {5'h00, q.done, q.nack,
                    q.state == CSC_H_RUN};
                `CSC_H_ADDR_RDATA: d.rdata = q.rx;
                default: d.rdata = 8'h00;
            endcase
        end
        if (wr) begin
            case (addr)
                `CSC_H_ADDR_OFFSET: d.off = wdata[6:0];
                `CSC_H_ADDR_WDATA: d.wdat = wdata;
                `CSC_H_ADDR_CTRL: begin
                    if (wdata[`CSC_H_CTRL_GO] && q.state == CSC_H_IDLE) begin
                        d.state = CSC_H_RUN;
                        d.rd_op = wdata[`CSC_H_CTRL_READ];
                        d.step = 3'h0;
                        d.qtr = 2'h0;
                        d.bitn = 4'h0;
                        d.div = 16'h0000;
                        d.nack = 1'b0;
                        d.done = 1'b0;
                    end
                end
                default: d.rdata = d.rdata;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '{state: CSC_H_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign bus.host_scl_o = 1'b0;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_scl_oe = q.scl_oe;
    assign bus.host_sda_oe = q.sda_oe;
    assign rdata = q.rdata;
endmodule

/* tb/csc_props.sv */
// wire checker for the host and device ends of the two-wire link
module csc_props #(
    parameter int QUARTER = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [7:0] low_q;
    logic [7:0] low_d;
    // clocks spent with the clock line low
    always_comb begin
        low_d = scl ? 8'h00 : low_q + 8'h01;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_q <= 8'h00;
        end else begin
            low_q <= low_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence high_span;
        scl [*8];
    endsequence
    sequence dev_hold;
        dev_sda_oe [*8];
    endsequence
    a_open_drain: assert property (
        !host_scl_o && !host_sda_o && !dev_sda_o)
        else $error("a line driven high");
    a_reset_idle: assert property ($fell(rst) |->
        !host_scl_oe && !host_sda_oe && !dev_sda_oe)
        else $error("lines not released after reset");
    a_dev_edge_low: assert property ($changed(dev_sda_oe) |->
        !scl && low_q inside {[2:4]})
        else $error("device data moved off the clock fall");
    a_start_by_host: assert property (
        $fell(sda) && scl && $past(scl) |-> host_sda_oe && !dev_sda_oe)
        else $error("start not made by host");
    a_stop_by_host: assert property (
        $rose(sda) && scl && $past(scl) |-> !$past(dev_sda_oe))
        else $error("device released data with clock high");
    a_scl_low_time: assert property ($rose(scl) |->
        low_q == 8'(2 * QUARTER))
        else $error("clock low time wrong");
    a_scl_high_min: assert property ($rose(scl) |-> high_span)
        else $error("clock high too short");
    a_dev_bit_hold: assert property ($rose(dev_sda_oe) |-> dev_hold)
        else $error("device bit shorter than a bit time");
    a_host_yields: assert property (dev_sda_oe && scl |-> !host_sda_oe)
        else $error("host drives data in device bit");
endmodule

/* tb/clock_synth_smbus_ctrl_regs_test.sv */
// bench for the host and device ends of the two-wire link
module clock_synth_smbus_ctrl_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int Q = 8;
    localparam int BQ = 2; // hand-made link clock: 8 clocks, 160 ns
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic want = 1'b0;
    logic chk_q = 1'b0;
    logic freq_select_first = 1'b1;
    logic freq_select_second = 1'b0;
    logic software_pci_clock_stop = 1'b0;
    logic [7:0] rdata;
    logic pci_drive_high, serial_ref_clock_oe, debug_port_cpu_clock_oe;
    logic cpu_clock1_oe, cpu_clock0_oe, serial_ref_clock_run, pci_clock_run;
    logic [1:0] freq_select_latched;
    logic [7:0] exp_q[$];
    logic [7:0] lf = 8'h55;
    logic [7:0] st, b0, b1;
    int mismatches = 0;
    int cmp_count = 0;
    csc_smbus_if bus();
    csc_smbus_if bus_b();
    always #10 clk = ~clk;
    csc_host #(.QUARTER(Q)) i_csc_host (.clk(clk), .rst(rst), .bus(bus),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    csc_device i_csc_device (.clk(clk), .rst(rst), .bus(bus),
        .freq_select_first(freq_select_first),
        .freq_select_second(freq_select_second),
        .software_pci_clock_stop(software_pci_clock_stop),
        .pci_drive_high(pci_drive_high),
        .serial_ref_clock_oe(serial_ref_clock_oe),
        .debug_port_cpu_clock_oe(debug_port_cpu_clock_oe),
        .cpu_clock1_oe(cpu_clock1_oe), .cpu_clock0_oe(cpu_clock0_oe),
        .serial_ref_clock_run(serial_ref_clock_run),
        .pci_clock_run(pci_clock_run),
        .freq_select_latched(freq_select_latched));
    // second device, driven by hand to break the address rule
    csc_device i_csc_device_b (.clk(clk), .rst(rst), .bus(bus_b),
        .freq_select_first(freq_select_first),
        .freq_select_second(freq_select_second),
        .software_pci_clock_stop(software_pci_clock_stop),
        .pci_drive_high(), .serial_ref_clock_oe(),
        .debug_port_cpu_clock_oe(), .cpu_clock1_oe(), .cpu_clock0_oe(),
        .serial_ref_clock_run(), .pci_clock_run(), .freq_select_latched());
    csc_props #(.QUARTER(Q)) i_csc_props (.clk(clk), .rst(rst),
        .host_scl_o(bus.host_scl_o), .host_scl_oe(bus.host_scl_oe),
        .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
        .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe),
        .scl(bus.scl), .sda(bus.sda));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // read data stand one cycle after the strobe
    always @(posedge clk) begin
        if (chk_q) check(rdata, exp_q.pop_front());
        chk_q <= rd && want;
    end
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic c,
                          input logic [7:0] e);
        if (c) exp_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        want <= c;
        @(posedge clk);
        rd <= 1'b0;
        #1;
    endtask
    task automatic xfer(input logic r, input logic [6:0] off,
                        input logic [7:0] d, input logic nack);
        int n;
        reg_wr(8'h00, {1'b0, off});
        reg_wr(8'h01, d);
        reg_wr(8'h02, {6'h00, r, 1'b1});
        n = 0;
        st = 8'h00;
        while (st[2] !== 1'b1 && n < 2000) begin
            reg_rd(8'h03, 1'b0, 8'h00);
            st = rdata;
            n++;
        end
        check({st[2], st[1]}, {1'b1, nack});
    endtask
    task automatic rd_byte(input logic [6:0] off, input logic [7:0] e);
        xfer(1'b1, off, 8'h00, 1'b0);
        reg_rd(8'h04, 1'b1, e);
    endtask
    task automatic run_chk(input logic [1:0] e);
        repeat (3) @(posedge clk);
        #1;
        check({serial_ref_clock_run, pci_clock_run}, e);
        @(posedge clk);
    endtask
    task automatic bb_wait(input logic sda_low, input logic scl_low);
        bus_b.host_sda_oe <= sda_low;
        repeat (BQ) @(posedge clk);
        bus_b.host_scl_oe <= scl_low;
        repeat (BQ) @(posedge clk);
    endtask
    task automatic bb_byte(input logic [8:0] d, input logic a);
        logic s;
        for (int i = 8; i >= 0; i--) begin
            bus_b.host_sda_oe <= ~d[i];
            repeat (BQ) @(posedge clk);
            bus_b.host_scl_oe <= 1'b0;
            repeat (BQ) @(posedge clk);
            s = bus_b.sda;
            repeat (BQ) @(posedge clk);
            bus_b.host_scl_oe <= 1'b1;
            repeat (BQ) @(posedge clk);
        end
        check(s, a);
    endtask
    initial begin
        bus_b.host_scl_o = 1'b0;
        bus_b.host_sda_o = 1'b0;
        bus_b.host_scl_oe = 1'b0;
        bus_b.host_sda_oe = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
        #1;
        check(pci_drive_high, 1'b1);
        check({serial_ref_clock_oe, debug_port_cpu_clock_oe, cpu_clock1_oe,
            cpu_clock0_oe}, 4'hF);
        check(freq_select_latched, 2'h1);
        rd_byte(7'h00, 8'h4D);
        rd_byte(7'h01, 8'h7F);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            b0 = {1'b0, lf[6], 4'h3, lf[1:0]};
            b1 = {i[0], lf[6], 3'h7, lf[2:0]};
            xfer(1'b0, 7'h00, b0, 1'b0);
            xfer(1'b0, 7'h01, b1, 1'b0);
            rd_byte(7'h00, {b0[7:2], 2'h1});
            rd_byte(7'h01, b1);
            check(pci_drive_high, lf[6]);
            check({serial_ref_clock_oe, debug_port_cpu_clock_oe,
                cpu_clock1_oe, cpu_clock0_oe}, {b1[6], b1[2:0]});
            @(posedge clk);
            software_pci_clock_stop <= 1'b1;
            run_chk({~b1[7], 1'b0});
            software_pci_clock_stop <= 1'b0;
            run_chk(2'h3);
        end
        xfer(1'b0, 7'h05, 8'hA5, 1'b0);
        rd_byte(7'h05, 8'h00);
        xfer(1'b0, 7'h20, 8'h00, 1'b1);
        xfer(1'b1, 7'h40, 8'h00, 1'b1);
        reg_rd(8'h07, 1'b1, 8'h00);
        bb_wait(1'b1, 1'b1);
        bb_byte(9'h1A9, 1'b1);
        bb_byte(9'h101, 1'b1);
        bb_wait(1'b1, 1'b0);
        bb_wait(1'b0, 1'b0);
        bb_wait(1'b1, 1'b1);
        bb_byte(9'h1A5, 1'b0);
        bb_byte(9'h101, 1'b0);
        bb_wait(1'b1, 1'b0);
        bb_wait(1'b0, 1'b0);
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule
